// ---- design/dcfifo_pkg.sv ----
// Constants and carriers for the 9-bit dual-port FIFO block.
// Assumes a single 200 MHz clock shared by the write and read ports.
//
// Overview of operation
// - Stores 9-bit words first-in first-out, 256 or 512 words deep.
// - Separate 9-bit input and output data buses.
// - Write on clock edge when primary enable low and secondary high.
// - Held enables write one word every cycle without gaps.
// - Output port has its own two read enables, like the input port.
// - Works with read and write clocks tied; here they share one clock.
// - Reads and writes proceed in the same cycle independently.
// - Flag mode: primary enable alone gates writes, only while not full.
// - Two-enable mode: write when primary low, secondary high, not full.
// - Secondary enable sampled at reset; high selects two-enable mode.
// - Active-low empty, full, almost-empty and almost-full flags.
// - Read only when both read enables low and buffer not empty.
// - Flag mode with load low accesses the offset register instead.
// - Empty flag made on read side, full flag on write side.
// - Reset returns to empty; outside applies reset before first use.
package dcfifo_pkg;
   localparam int DATA_W = 9;
   localparam int DEPTH_SMALL = 256;
   localparam int DEPTH_LARGE = 512;
   localparam int STAGE_DEPTH = 8;
   localparam int OFS_W = 9;
   // Default almost-flag offsets, in words from either end
   localparam logic [OFS_W-1:0] OFS_EMPTY_RST = 9'h007;
   localparam logic [OFS_W-1:0] OFS_FULL_RST = 9'h007;

   typedef logic [DATA_W-1:0] dcfifo_word_t;

   typedef struct packed {
      logic empty_n;
      logic full_n;
      logic almost_empty_n;
      logic almost_full_n;
   } dcfifo_flags_s;

   typedef enum logic [1:0] {
      DCFIFO_MODE_FLAGS = 2'h1,
      DCFIFO_MODE_TWO_WE = 2'h2
   } dcfifo_mode_e;
endpackage

// ---- design/dcfifo_stage.sv ----
// Small valid/ready FIFO used as the output staging buffer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dcfifo_stage #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire push = in_valid_in && (cnt_r != (AW+1)'(DEPTH));
   wire pop = out_ready_in && (cnt_r != '0);

   assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_r != '0);
   assign out_data_out = mem_r[rp_r];

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_r[wp_r] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= AW'(wp_r + 1'b1);
         if (pop) rp_r <= AW'(rp_r + 1'b1);
         cnt_r <= (AW+1)'(cnt_r + push - pop);
      end
   end
endmodule // dcfifo_stage

// ---- design/dcfifo_top.sv ----
// Top of the 9-bit FIFO: write port, storage, flags and read port.
// Assumes both ports run on sys_clk_in (tied-clock use) and that the
// outside applies rst_in before the first access.
`timescale 1ns/1ps
module dcfifo_top #(
   parameter int DEPTH = dcfifo_pkg::DEPTH_SMALL
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Write port
   input wire logic [dcfifo_pkg::DATA_W-1:0] data_in_bus_in,
   input wire logic write_enable_primary_n_in,
   input wire logic write_enable_secondary_or_offset_load_in,
   // Read port
   input wire logic read_enable_a_n_in,
   input wire logic read_enable_b_n_in,
   input wire logic output_enable_n_in,
   output logic [dcfifo_pkg::DATA_W-1:0] data_out_bus_out,
   output logic [dcfifo_pkg::DATA_W-1:0] data_out_bus_oe_n_out,
   // Flags
   output dcfifo_pkg::dcfifo_flags_s flags_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam int SD = dcfifo_pkg::STAGE_DEPTH;

   // ----------------------------------------------------------------
   // Mode strap
   // ----------------------------------------------------------------
   dcfifo_pkg::dcfifo_mode_e mode_r;
   wire strap_two_we = write_enable_secondary_or_offset_load_in;
   wire two_we = (mode_r == dcfifo_pkg::DCFIFO_MODE_TWO_WE);
   wire offset_load_n = write_enable_secondary_or_offset_load_in;

   // Caught by a clocked process while reset is held
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         mode_r <= strap_two_we ? dcfifo_pkg::DCFIFO_MODE_TWO_WE
                                : dcfifo_pkg::DCFIFO_MODE_FLAGS;
      end
   end

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   dcfifo_pkg::dcfifo_word_t mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [CW-1:0] count_r;
   logic [dcfifo_pkg::OFS_W-1:0] ofs_empty_r;
   logic [dcfifo_pkg::OFS_W-1:0] ofs_full_r;
   logic ofs_wsel_r;
   logic ofs_rsel_r;

   wire full = (count_r == CW'(DEPTH));
   wire empty = (count_r == '0);
   wire wen_primary = !write_enable_primary_n_in;
   // Flag mode: the primary enable alone gates; load low diverts
   wire wr_flags = wen_primary && offset_load_n && !full;
   wire wr_two = wen_primary && write_enable_secondary_or_offset_load_in
                 && !full;
   wire wr_fire = two_we ? wr_two : wr_flags;
   wire ofs_write = !two_we && wen_primary && !offset_load_n;

   // ----------------------------------------------------------------
   // Read request and output staging
   // ----------------------------------------------------------------
   // The stage buffer decouples the core from the output register so
   // that a stalled output never blocks the write side.
   wire rd_req = !read_enable_a_n_in && !read_enable_b_n_in;
   wire ofs_read = !two_we && rd_req && !offset_load_n;
   wire stg_in_ready;
   wire stg_out_valid;
   dcfifo_pkg::dcfifo_word_t stg_out_data;
   // In two-enable mode the shared pin is a write enable, never a load
   wire rd_gate = two_we || offset_load_n;
   wire rd_core = rd_req && rd_gate && !empty && stg_in_ready;
   logic rd_pend_r;
   wire stg_pop = rd_pend_r && stg_out_valid;
   wire [dcfifo_pkg::OFS_W-1:0] ofs_rdata =
      ofs_rsel_r ? ofs_full_r : ofs_empty_r;

   dcfifo_stage #(
      .WIDTH(dcfifo_pkg::DATA_W),
      .DEPTH(SD)
   ) u_stage (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .in_valid_in(rd_core),
      .in_ready_out(stg_in_ready),
      .in_data_in(mem_r[rptr_r]),
      .out_valid_out(stg_out_valid),
      .out_ready_in(stg_pop),
      .out_data_out(stg_out_data)
   );

   always_ff @(posedge sys_clk_in) begin
      if (wr_fire) begin
         mem_r[wptr_r] <= data_in_bus_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
      end else begin
         if (wr_fire) wptr_r <= AW'(wptr_r + 1'b1);
         if (rd_core) rptr_r <= AW'(rptr_r + 1'b1);
         count_r <= CW'(count_r + wr_fire - rd_core);
      end
   end

   // Offsets load empty then full, alternating on each offset write
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ofs_empty_r <= dcfifo_pkg::OFS_EMPTY_RST;
         ofs_full_r <= dcfifo_pkg::OFS_FULL_RST;
         ofs_wsel_r <= 1'b0;
         ofs_rsel_r <= 1'b0;
      end else begin
         if (ofs_write) begin
            ofs_wsel_r <= !ofs_wsel_r;
            if (ofs_wsel_r) ofs_full_r <= data_in_bus_in;
            else ofs_empty_r <= data_in_bus_in;
         end
         if (ofs_read) ofs_rsel_r <= !ofs_rsel_r;
      end
   end

   // ----------------------------------------------------------------
   // Output register
   // ----------------------------------------------------------------
   // One-cycle pop latency: the stage head is taken the edge after the
   // core read, so data appears two edges after the request.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rd_pend_r <= 1'b0;
         data_out_bus_out <= '0;
         data_out_bus_oe_n_out <= '1;
      end else begin
         rd_pend_r <= 1'b1;
         if (stg_pop) data_out_bus_out <= stg_out_data;
         else if (ofs_read) data_out_bus_out <= ofs_rdata;
         data_out_bus_oe_n_out <=
            {dcfifo_pkg::DATA_W{output_enable_n_in}};
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   wire [CW-1:0] count_nxt = CW'(count_r + wr_fire - rd_core);
   wire ae_nxt = (count_nxt <= CW'(ofs_empty_r));
   wire af_nxt = (count_nxt >= CW'(CW'(DEPTH) - CW'(ofs_full_r)));

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         flags_out <= '{empty_n: 1'b0, full_n: 1'b1,
                        almost_empty_n: 1'b0, almost_full_n: 1'b1};
      end else begin
         flags_out.empty_n <= (count_nxt != '0);
         flags_out.full_n <= (count_nxt != CW'(DEPTH));
         flags_out.almost_empty_n <= !ae_nxt;
         flags_out.almost_full_n <= !af_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_full_blocks_write: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) full |-> !wr_fire)
      else $error("write taken while full");
   a_two_we_write: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) (two_we && wen_primary && !full &&
      write_enable_secondary_or_offset_load_in) |-> wr_fire)
      else $error("two-enable write dropped");
   a_flag_mode_write: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) (!two_we && wen_primary && !full &&
      offset_load_n) |-> wr_fire)
      else $error("flag-mode write dropped");
   a_read_needs_both: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) !rd_req |-> !rd_core)
      else $error("read without both enables");
   a_oe_drives: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) !output_enable_n_in |=>
      data_out_bus_oe_n_out == '0)
      else $error("bus released while enabled");
   a_empty_no_read: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) (empty && !wr_fire) |=> empty)
      else $error("read taken while empty");
   a_write_counts: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) (wr_fire && !rd_core) |=>
      count_r == CW'($past(count_r) + 1'b1))
      else $error("write not counted");
   a_read_counts: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) (rd_core && !wr_fire) |=>
      count_r == CW'($past(count_r) - 1'b1))
      else $error("read not counted");
   a_empty_flag: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) flags_out.empty_n == (count_r != '0))
      else $error("empty flag wrong");
   a_full_flag: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) flags_out.full_n == !full)
      else $error("full flag wrong");
   a_mode_write_gate: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) (two_we &&
      !write_enable_secondary_or_offset_load_in) |-> !wr_fire)
      else $error("write without secondary enable");
   a_reset_clears: assert property (@(posedge sys_clk_in)
      rst_in |=> (count_r == '0 && !flags_out.empty_n))
      else $error("reset did not empty");
   a_oe_follows: assert property (@(posedge sys_clk_in)
      disable iff (rst_in) output_enable_n_in |=>
      data_out_bus_oe_n_out == '1)
      else $error("bus driven while disabled");
endmodule // dcfifo_top

// ---- verification/dcfifo_bus_model.sv ----
// Far-side model of the bus wires that the read port drives.
// Assumes one clock and no pull-up or pull-down on those wires.
`timescale 1ns/1ps
module dcfifo_bus_model (
   // Clock
   input wire logic sys_clk_in,
   // Read port pins
   input wire logic [dcfifo_pkg::DATA_W-1:0] drv_in,
   input wire logic [dcfifo_pkg::DATA_W-1:0] oe_n_in,
   // Level seen on the bus
   output logic [dcfifo_pkg::DATA_W-1:0] bus_out
);
   logic [dcfifo_pkg::DATA_W-1:0] seen_r;
   always_ff @(posedge sys_clk_in) begin
      seen_r <= bus_out;
   end
   // Released bits flip every cycle, so a stale word never passes
   always_comb begin
      for (int i = 0; i < dcfifo_pkg::DATA_W; i++) begin
         bus_out[i] = oe_n_in[i] ? ~seen_r[i] : drv_in[i];
      end
   end
endmodule // dcfifo_bus_model

// ---- verification/tb_dcfifo_top.sv ----
// Self-checking bench: enable table, fill, drain, flag mode, reset, OE.
// Assumes the design files and dcfifo_bus_model are compiled first.
`timescale 1ns/1ps
module tb_dcfifo_top;
   localparam int DEPTH = 256;
   typedef struct packed {logic w1n, w2, ran, rbn, st, pop;} dcfifo_row_s;
   dcfifo_row_s rows [5] = '{6'h13, 6'h30, 6'h00, 6'h1a, 6'h16};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [8:0] din = 9'h000;
   logic we1_n = 1'b1;
   logic we2 = 1'b1;
   logic ra_n = 1'b1;
   logic rb_n = 1'b1;
   logic oe_n = 1'b0;
   logic [8:0] dout, oe_bus, bus, last, d;
   dcfifo_pkg::dcfifo_flags_s flags;
   int failures = 0;
   int check_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   dcfifo_top #(.DEPTH(DEPTH)) u_dcfifo_top (.sys_clk_in(sys_clk),
      .rst_in(rst), .data_in_bus_in(din), .write_enable_primary_n_in(we1_n),
      .write_enable_secondary_or_offset_load_in(we2),
      .read_enable_a_n_in(ra_n), .read_enable_b_n_in(rb_n),
      .output_enable_n_in(oe_n), .data_out_bus_out(dout),
      .data_out_bus_oe_n_out(oe_bus), .flags_out(flags));
   dcfifo_bus_model u_dcfifo_bus_model (.sys_clk_in(sys_clk),
      .drv_in(dout), .oe_n_in(oe_bus), .bus_out(bus));
   // ----------------------------------------
   // Drivers and compares
   // ----------------------------------------
   task automatic put(input logic w1n, w2n, ran, rbn, input logic [8:0] v);
      @(posedge sys_clk);
      we1_n <= w1n;
      we2 <= w2n;
      ra_n <= ran;
      rb_n <= rbn;
      din <= v;
   endtask
   // Idle cycles, then step past the edge so outputs have landed
   task automatic settle(input int n);
      repeat (n) put(1'b1, 1'b1, 1'b1, 1'b1, 9'h000);
      #1;
   endtask
   task automatic cmp_word(input logic [8:0] got, exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flags(input logic [3:0] got, exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [8:0] exp);
      put(1'b1, 1'b1, 1'b0, 1'b0, 9'h000);
      settle(3);
      cmp_word(dout, exp);
   endtask
   task automatic do_reset(input logic strap);
      @(posedge sys_clk);
      rst <= 1'b1;
      we2 <= strap;
      repeat (16) @(posedge sys_clk);
      #1;
      cmp_flags(flags, 4'h5);
      cmp_word(dout, 9'h000);
      cmp_word(oe_bus, 9'h1ff);
      @(posedge sys_clk);
      rst <= 1'b0;
      we2 <= 1'b1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      report_and_stop();
   end
   initial begin
      do_reset(1'b1);
      $display("test reset done");
      last = 9'h000;
      foreach (rows[i]) begin
         d = 9'h150 + 9'(i);
         put(rows[i].w1n, rows[i].w2, 1'b1, 1'b1, d);
         settle(1);
         cmp_flags(flags, rows[i].st ? 4'hd : 4'h5);
         put(1'b1, 1'b1, rows[i].ran, rows[i].rbn, 9'h000);
         settle(3);
         if (rows[i].pop) last = d;
         cmp_word(dout, last);
         if (rows[i].st && !rows[i].pop) rd_chk(d);
         if (rows[i].st) last = d;
         cmp_flags(flags, 4'h5);
      end
      $display("test rows done");
      // Almost flags switch at the default offset of 7 from either end
      for (int i = 0; i < DEPTH; i++) begin
         put(1'b0, 1'b1, 1'b1, 1'b1, 9'(i));
         #1;
         if (i == 7 || i == 249) cmp_flags(flags, i == 7 ? 4'hd : 4'he);
         if (i == 8 || i == 248) cmp_flags(flags, 4'hf);
      end
      put(1'b0, 1'b1, 1'b1, 1'b1, 9'h1aa);
      settle(1);
      cmp_flags(flags, 4'ha);
      for (int i = 0; i < DEPTH; i++) rd_chk(9'(i));
      cmp_flags(flags, 4'h5);
      $display("test fill drain done");
      put(1'b0, 1'b1, 1'b1, 1'b1, 9'h0a5);
      put(1'b0, 1'b1, 1'b0, 1'b0, 9'h15a);
      settle(3);
      cmp_word(dout, 9'h0a5);
      cmp_flags(flags, 4'hd);
      rd_chk(9'h15a);
      $display("test same cycle done");
      do_reset(1'b0);
      put(1'b0, 1'b0, 1'b1, 1'b1, 9'h002);
      put(1'b0, 1'b0, 1'b1, 1'b1, 9'h003);
      put(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
      settle(3);
      cmp_word(dout, 9'h002);
      put(1'b1, 1'b0, 1'b0, 1'b0, 9'h000);
      settle(3);
      cmp_word(dout, 9'h003);
      cmp_flags(flags, 4'h5);
      for (int i = 0; i < 3; i++) begin
         put(1'b0, 1'b1, 1'b1, 1'b1, 9'h020 + 9'(i));
         settle(1);
         cmp_flags(flags, i < 2 ? 4'hd : 4'hf);
      end
      $display("test flag mode done");
      do_reset(1'b1);
      rd_chk(9'h000);
      cmp_flags(flags, 4'h5);
      $display("test mid reset done");
      @(posedge sys_clk);
      oe_n <= 1'b1;
      settle(2);
      cmp_word(oe_bus, 9'h1ff);
      @(posedge sys_clk);
      oe_n <= 1'b0;
      settle(2);
      cmp_word(oe_bus, 9'h000);
      cmp_word(bus, dout);
      $display("test output enable done");
      report_and_stop();
   end
endmodule // tb_dcfifo_top
